// >>> design/psm_pkg.sv
// Package for the program space access mapper: register map, field layout and cycle figures.
// Assumes a single core clock domain; shared by the mapper module and its bench.
package psm_pkg;
    localparam int PSM_PADDR_W = 24;
    localparam int PSM_WORD_W = 24;
    localparam int PSM_DATA_W = 16;
    localparam int PSM_PC_W = 23;
    localparam int PSM_CFG_BIT = 23;
    localparam int PSM_WIN_LOW_W = 15;
    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] PSM_OFF_TABLE_PAGE = 8'h00;
    localparam logic [7:0] PSM_OFF_WINDOW_PAGE = 8'h04;
    localparam logic [7:0] PSM_OFF_CORE_CONTROL = 8'h08;
    localparam logic [7:0] PSM_OFF_STATUS = 8'h0c;
    // Field positions and reset values.
    localparam int PSM_WIN_EN_POS = 2;
    localparam logic [7:0] PSM_TABLE_PAGE_RST = 8'h00;
    localparam logic [7:0] PSM_WINDOW_PAGE_RST = 8'h00;
    localparam logic [15:0] PSM_CORE_CONTROL_RST = 16'h0000;
    // Extra cycles added by windowed accesses.
    localparam logic [1:0] PSM_EXTRA_SHORT = 2'h1;
    localparam logic [1:0] PSM_EXTRA_LONG = 2'h2;
    localparam logic [1:0] PSM_RESP_OKAY = 2'h0;
    localparam logic [1:0] PSM_RESP_SLVERR = 2'h2;
    // Access kinds issued by the core.
    typedef enum logic [2:0] {
        PSM_K_NONE = 3'h0,
        PSM_K_FETCH = 3'h1,
        PSM_K_TBL_LOW = 3'h2,
        PSM_K_TBL_HIGH = 3'h3,
        PSM_K_DATA = 3'h4
    } psm_kind_e;
    // Instruction classes for window timing.
    typedef enum logic [1:0] {
        PSM_C_OTHER = 2'h0,
        PSM_C_MAC = 2'h1,
        PSM_C_MOVE = 2'h2,
        PSM_C_DMOVE = 2'h3
    } psm_class_e;
endpackage

// >>> design/psm_mapper.sv
// Program space access mapper: forms 24-bit program addresses and steers program data to the core.
// Assumes the core holds a request until psm_ack and sits on the same aclk; memory answers in one cycle.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns

// Summary of operation
// - Program space holds 4M words, addressed by 24 bits from three sources.
// - Fetch address comes from a 23-bit PC stepping by two.
// - Non-table accesses stay below 0x800000 with bit 23 cleared.
// - Address bit 23 selects configuration space, reachable only by table accesses.
// - Table address is table page joined with the 16-bit effective address.
// - Low table ops touch the low word; high ops reach the upper byte.
// - Word low table read returns program bits 15..0 unchanged.
// - Byte low table read returns bits 7..0 or 15..8 by byte select.
// - Word high table read returns bits 23..16 low, zero upper byte.
// - Byte high read returns bits 23..16 for select zero, zero otherwise.
// - Window enable plus address MSB maps upper data space to program page.
// - Window address is window page bits 22..15 with address bits 14..0.
// - Windowed reads return only the low 16 bits of the word.
// - The data window is suspended while a table access runs.
// - Outside repeat, multiply, move and double move window accesses add one cycle.
// - Outside repeat, other window accesses add two cycles.
// - In repeat, edge iterations add two cycles, others run single-cycle.
module psm_mapper
    import psm_pkg::*;
(
    input wire logic aclk, // Core clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [31:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [31:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic psm_req, // Core access request, held until ack.
    input wire logic [2:0] psm_kind, // Access kind.
    input wire logic psm_write, // Table write when high.
    input wire logic psm_byte, // Byte-sized access.
    input wire logic [1:0] psm_class, // Instruction class.
    input wire logic psm_in_repeat, // Inside a repeat loop.
    input wire logic psm_rep_edge, // First, last, interrupt exit or re-entry iteration.
    input wire logic [PSM_PC_W-1:0] psm_pc, // Program counter.
    input wire logic [15:0] psm_ea, // Data effective address.
    input wire logic [15:0] psm_wdata, // Table write data.
    input wire logic [PSM_WORD_W-1:0] pm_rdata, // Program memory read word.
    output logic [PSM_PADDR_W-1:0] pm_addr, // Program memory address.
    output logic pm_rd, // Program memory read strobe.
    output logic pm_wr_low, // Low word write strobe.
    output logic pm_wr_high, // High byte write strobe.
    output logic [15:0] pm_wdata, // Program memory write data.
    output logic psm_ack, // Access complete pulse.
    output logic [PSM_WORD_W-1:0] psm_fetch_word, // Fetched instruction word.
    output logic [15:0] psm_rdata, // Data returned to core.
    output logic psm_stall, // Pipeline stall.
    output logic psm_ds_pass // Data access not windowed: served by data space.
);
    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    logic [7:0] table_page_register;
    logic [7:0] window_page_register;
    logic [15:0] core_control_register;
    logic [15:0] win_count;
    logic aw_held, w_held;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    typedef enum logic [3:0] {
        PSM_S_IDLE = 4'b0001,
        PSM_S_MEM = 4'b0010,
        PSM_S_WAIT = 4'b0100,
        PSM_S_DONE = 4'b1000
    } psm_state_e;
    psm_state_e state;
    logic [1:0] wait_cnt;

    wire window_enable_bit = core_control_register[PSM_WIN_EN_POS];

    // Write channels are taken independently; the write happens once both are held.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr_q <= s_axi_awaddr[7:0];
            end else if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (aw_held && w_held && !s_axi_bvalid) begin
                w_held <= 1'b0;
            end
        end
    end

    wire do_write = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    // Register updates; the status counter is read-only.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            table_page_register <= PSM_TABLE_PAGE_RST;
            window_page_register <= PSM_WINDOW_PAGE_RST;
            core_control_register <= PSM_CORE_CONTROL_RST;
        end else if (do_write) begin
            if (aw_addr_q == PSM_OFF_TABLE_PAGE && w_strb_q[0])
                table_page_register <= w_data_q[7:0];
            if (aw_addr_q == PSM_OFF_WINDOW_PAGE && w_strb_q[0])
                window_page_register <= w_data_q[7:0];
            if (aw_addr_q == PSM_OFF_CORE_CONTROL) begin
                if (w_strb_q[0])
                    core_control_register[7:0] <= w_data_q[7:0];
                if (w_strb_q[1])
                    core_control_register[15:8] <= w_data_q[15:8];
            end
        end
    end

    function automatic logic psm_mapped(input logic [7:0] a);
        psm_mapped = (a == PSM_OFF_TABLE_PAGE) || (a == PSM_OFF_WINDOW_PAGE) ||
                     (a == PSM_OFF_CORE_CONTROL) || (a == PSM_OFF_STATUS);
    endfunction

    // Write response one cycle after both channels are held.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PSM_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= psm_mapped(aw_addr_q) ? PSM_RESP_OKAY : PSM_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    // Read data one cycle after the address; unmapped answers SLVERR with zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= PSM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= psm_mapped(s_axi_araddr[7:0]) ? PSM_RESP_OKAY : PSM_RESP_SLVERR;
            unique case (s_axi_araddr[7:0])
                PSM_OFF_TABLE_PAGE: s_axi_rdata <= {24'h000000, table_page_register};
                PSM_OFF_WINDOW_PAGE: s_axi_rdata <= {24'h000000, window_page_register};
                PSM_OFF_CORE_CONTROL: s_axi_rdata <= {16'h0000, core_control_register};
                PSM_OFF_STATUS: s_axi_rdata <= {16'h0000, win_count};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Address construction
    // ---------------------------------------------------------------
    wire is_table = (psm_kind == PSM_K_TBL_LOW) || (psm_kind == PSM_K_TBL_HIGH);
    // window suspended for tables. window decode.
    wire is_window = (psm_kind == PSM_K_DATA) && window_enable_bit && psm_ea[15] && !is_table;
    logic [PSM_PADDR_W-1:0] next_addr;
    logic [1:0] extra;

    // Pick the address source; only the table path may raise bit 23.
    always_comb begin
        next_addr = '0;
        unique case (psm_kind)
            // PC word steps by two. bit 23 held low.
            PSM_K_FETCH: next_addr = {1'b0, psm_pc[PSM_PC_W-1:1], 1'b0};
            // page joined with address. page bit 7 picks configuration.
            PSM_K_TBL_LOW, PSM_K_TBL_HIGH: next_addr = {table_page_register, psm_ea};
            // window page over low 15 bits. bit 23 held low.
            PSM_K_DATA: next_addr = {1'b0, window_page_register, psm_ea[PSM_WIN_LOW_W-1:0]};
            default: next_addr = '0;
        endcase
    end

    // Extra cycles for windowed accesses; each one is a wait state after the memory cycle.
    always_comb begin
        extra = 2'h0;
        if (is_window) begin
            // loop edges cost two, middle iterations none.
            if (psm_in_repeat)
                extra = psm_rep_edge ? PSM_EXTRA_LONG : 2'h0;
            else if (psm_class != PSM_C_OTHER)
                extra = PSM_EXTRA_SHORT;
            else
                extra = PSM_EXTRA_LONG;
        end
    end

    // The core still holds its request at the edge where it sees ack, so that edge never takes.
    wire start = (state == PSM_S_IDLE) && psm_req && !psm_ack && (psm_kind != PSM_K_NONE) &&
                 ((psm_kind != PSM_K_DATA) || is_window);

    // ---------------------------------------------------------------
    // Access sequencer
    // ---------------------------------------------------------------
    logic kind_high, kind_table, kind_fetch, byte_q, sel_q;

    // one 24-bit address per access to the 4M-word space.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= PSM_S_IDLE;
            wait_cnt <= 2'h0;
            pm_addr <= '0;
            pm_rd <= 1'b0;
            pm_wr_low <= 1'b0;
            pm_wr_high <= 1'b0;
            pm_wdata <= 16'h0000;
            kind_high <= 1'b0;
            kind_table <= 1'b0;
            kind_fetch <= 1'b0;
            byte_q <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            pm_rd <= 1'b0;
            pm_wr_low <= 1'b0;
            pm_wr_high <= 1'b0;
            unique case (state)
                PSM_S_IDLE: if (start) begin
                    state <= PSM_S_MEM;
                    pm_addr <= next_addr;
                    // low ops write the low word, high ops the upper byte.
                    pm_rd <= !(is_table && psm_write);
                    pm_wr_low <= (psm_kind == PSM_K_TBL_LOW) && psm_write;
                    pm_wr_high <= (psm_kind == PSM_K_TBL_HIGH) && psm_write;
                    pm_wdata <= psm_wdata;
                    kind_high <= psm_kind == PSM_K_TBL_HIGH;
                    kind_table <= is_table;
                    kind_fetch <= psm_kind == PSM_K_FETCH;
                    byte_q <= psm_byte;
                    sel_q <= psm_ea[0];
                    wait_cnt <= extra;
                end
                PSM_S_MEM: state <= (wait_cnt == 2'h0) ? PSM_S_DONE : PSM_S_WAIT;
                PSM_S_WAIT: begin
                    wait_cnt <= wait_cnt - 2'h1;
                    if (wait_cnt == 2'h1)
                        state <= PSM_S_DONE;
                end
                PSM_S_DONE: state <= PSM_S_IDLE;
                default: state <= PSM_S_IDLE;
            endcase
        end
    end

    logic [PSM_WORD_W-1:0] word_q;
    logic [15:0] next_rdata;

    // Capture the memory word at the end of the cycle in which the read strobe stands.
    always_ff @(posedge aclk) begin
        if (!aresetn)
            word_q <= '0;
        else if (state == PSM_S_MEM)
            word_q <= pm_rdata;
    end

    // Lane steering toward the core's data path.
    always_comb begin
        next_rdata = word_q[15:0];
        if (kind_table && kind_high) begin
            // upper byte zero. byte access with select one returns zero.
            next_rdata = (byte_q && sel_q) ? 16'h0000 : {8'h00, word_q[23:16]};
        end else if (kind_table && byte_q) begin
            next_rdata = {8'h00, sel_q ? word_q[15:8] : word_q[7:0]};
        end else begin
            // low word unchanged. window drops upper byte.
            next_rdata = word_q[15:0];
        end
    end

    // Answer registers, plus the window access counter shown in status.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psm_ack <= 1'b0;
            psm_rdata <= 16'h0000;
            psm_fetch_word <= '0;
            win_count <= 16'h0000;
        end else begin
            psm_ack <= state == PSM_S_DONE;
            if (state == PSM_S_DONE) begin
                psm_rdata <= kind_fetch ? 16'h0000 : next_rdata;
                if (kind_fetch)
                    psm_fetch_word <= word_q;
                if (!kind_fetch && !kind_table)
                    win_count <= win_count + 16'h0001;
            end
        end
    end

    // stall while the port is busy for data or tables.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psm_stall <= 1'b0;
            psm_ds_pass <= 1'b0;
        end else begin
            psm_stall <= (start && psm_kind != PSM_K_FETCH) ||
                         ((state == PSM_S_MEM || state == PSM_S_WAIT) && !kind_fetch);
            psm_ds_pass <= psm_req && (psm_kind == PSM_K_DATA) && !is_window;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_fetch_bit23;
        @(posedge aclk) disable iff (!aresetn) (state == PSM_S_IDLE && start && !is_table) |=> !pm_addr[23];
    endproperty
    a_fetch_bit23: assert property (p_fetch_bit23) else $error("Non-table access set bit 23.");
    property p_table_addr;
        @(posedge aclk) disable iff (!aresetn) (start && is_table) |=>
            pm_addr == {$past(table_page_register), $past(psm_ea)};
    endproperty
    a_table_addr: assert property (p_table_addr) else $error("Table address wrong.");
    property p_win_addr;
        @(posedge aclk) disable iff (!aresetn) (start && is_window) |=>
            pm_addr == {1'b0, $past(window_page_register), $past(psm_ea[14:0])};
    endproperty
    a_win_addr: assert property (p_win_addr) else $error("Window address wrong.");
    property p_fetch_addr;
        @(posedge aclk) disable iff (!aresetn) (start && psm_kind == PSM_K_FETCH) |=>
            pm_addr == {1'b0, $past(psm_pc[22:1]), 1'b0};
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("Fetch address wrong.");
    property p_high_zero;
        @(posedge aclk) disable iff (!aresetn) (psm_ack && kind_table && kind_high) |-> psm_rdata[15:8] == 8'h00;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("High read upper byte not zero.");
    property p_short_extra;
        @(posedge aclk) disable iff (!aresetn) (start && is_window && !psm_in_repeat && psm_class != PSM_C_OTHER)
            |=> ##3 psm_ack;
    endproperty
    a_short_extra: assert property (p_short_extra) else $error("Short window timing wrong.");
    property p_long_extra;
        @(posedge aclk) disable iff (!aresetn) (start && is_window && !psm_in_repeat && psm_class == PSM_C_OTHER)
            |=> !psm_ack [*4] ##1 psm_ack;
    endproperty
    a_long_extra: assert property (p_long_extra) else $error("Long window timing wrong.");
    property p_rep_mid;
        @(posedge aclk) disable iff (!aresetn) (start && is_window && psm_in_repeat && !psm_rep_edge) |=> ##2 psm_ack;
    endproperty
    a_rep_mid: assert property (p_rep_mid) else $error("Repeat middle iteration slow.");
    property p_no_win_table;
        @(posedge aclk) disable iff (!aresetn) (state == PSM_S_DONE && kind_table) |=>
            win_count == $past(win_count);
    endproperty
    a_no_win_table: assert property (p_no_win_table) else $error("Window active in table access.");
    property p_stall;
        @(posedge aclk) disable iff (!aresetn) (start && psm_kind != PSM_K_FETCH) |=> psm_stall [*2];
    endproperty
    a_stall: assert property (p_stall) else $error("Pipeline not stalled.");
    c_window: cover property (@(posedge aclk) disable iff (!aresetn) start && is_window ##[1:6] psm_ack);
    c_table_hi: cover property (@(posedge aclk) disable iff (!aresetn) start && psm_kind == PSM_K_TBL_HIGH);
    c_fetch: cover property (@(posedge aclk) disable iff (!aresetn) start && psm_kind == PSM_K_FETCH);
    c_axi_wr: cover property (@(posedge aclk) disable iff (!aresetn) do_write);
endmodule // psm_mapper

// >>> bench/psm_mem_model.sv
// Program memory model that sits on the far side of the mapper's program port.
// Assumes registered strobes; answers while the read strobe stands, updated on the falling edge.
`timescale 1ns/1ns
module psm_mem_model (
    input wire logic aclk, // Core clock.
    input wire logic [23:0] pm_addr, // Program address.
    input wire logic pm_rd, // Read strobe.
    input wire logic pm_wr_low, // Low word write strobe.
    input wire logic pm_wr_high, // High byte write strobe.
    input wire logic [15:0] pm_wdata, // Write data.
    output logic [23:0] pm_rdata // Read word.
);
    logic [23:0] mem [logic [23:0]];
    logic [23:0] wa;
    // Unwritten words hold an address pattern, so a misrouted address reads wrong data.
    function automatic logic [23:0] fill(input logic [23:0] a);
        return {a[23:16] ^ a[8:1], a[15:0] ^ 16'h5a5a};
    endfunction
    initial pm_rdata = 24'h0;
    // Outside the answer cycle the bus toggles, so stale data never passes for an answer.
    // The falling edge puts the word up in time for the mapper's capture at the next rising edge.
    always @(negedge aclk) begin
        wa = {pm_addr[23:1], 1'b0};
        if ((pm_rd || pm_wr_low || pm_wr_high) && !mem.exists(wa)) mem[wa] = fill(wa);
        if (pm_wr_low) mem[wa][15:0] = pm_wdata;
        if (pm_wr_high) mem[wa][23:16] = pm_wdata[7:0];
        pm_rdata <= pm_rd ? mem[wa] : ~pm_rdata;
    end
endmodule // psm_mem_model

// >>> bench/psm_mapper_tb.sv
// Self-checking bench for the program space access mapper.
// Assumes the memory model on the program port; the bench plays the core and the AXI4-Lite master.
`timescale 1ns/1ns
module psm_mapper_tb
    import psm_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, psm_class = 2'h0;
    logic psm_req = 1'b0, psm_write = 1'b0, psm_byte = 1'b0, psm_in_repeat = 1'b0, psm_rep_edge = 1'b0;
    logic [2:0] psm_kind = 3'h0;
    logic [22:0] psm_pc = '0;
    logic [15:0] psm_ea = '0, psm_wdata = '0, pm_wdata, psm_rdata;
    logic [23:0] pm_rdata, pm_addr, psm_fetch_word;
    logic pm_rd, pm_wr_low, pm_wr_high, psm_ack, psm_stall, psm_ds_pass;
    int mismatches = 0;
    int checked = 0;

    psm_mapper psm_mapper_inst (.*);
    psm_mem_model psm_mem_model_inst (.aclk(aclk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_wr_low(pm_wr_low),
        .pm_wr_high(pm_wr_high), .pm_wdata(pm_wdata), .pm_rdata(pm_rdata));

    always #10 aclk = ~aclk;

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [23:0] pat(input logic [23:0] a);
        return {a[23:16] ^ a[8:1], a[15:0] ^ 16'h5a5a};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Write address and data are offered together and each dropped once taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        chk(s_axi_bvalid, 1'b1);
        chk(s_axi_bresp, PSM_RESP_OKAY);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp);
        int n;
        @(posedge aclk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        chk(s_axi_rvalid, 1'b1);
        chk(s_axi_rdata, exp);
        chk(s_axi_rresp, rsp);
    endtask

    // One core request held until ack; lat 0 means the request must be ignored.
    task automatic acc(input logic [2:0] k, input logic [15:0] ea, input int lat, input logic [23:0] ad,
        input logic [23:0] dat);
        int n;
        logic [23:0] ga;
        logic st;
        @(posedge aclk);
        psm_kind <= k;
        psm_ea <= ea;
        psm_req <= 1'b1;
        n = 0;
        st = 1'b0;
        ga = '0;
        do begin
            @(posedge aclk);
            n++;
            if (pm_rd || pm_wr_low || pm_wr_high) ga = pm_addr;
            st = st | psm_stall;
        end while (!psm_ack && n < (lat != 0 ? lat + 4 : 10));
        psm_req <= 1'b0;
        if (lat == 0) begin
            chk(psm_ack, 1'b0);
            chk(psm_ds_pass, 1'b1);
        end else begin
            chk(n, lat + 1);
            chk(ga & 24'hfffffe, ad);
            chk(st, k != PSM_K_FETCH);
            if (!psm_write) chk(k == PSM_K_FETCH ? psm_fetch_word : (psm_byte ? {8'h0, psm_rdata[7:0]} : psm_rdata), dat);
        end
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        logic [23:0] w;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(PSM_OFF_TABLE_PAGE, {24'h0, PSM_TABLE_PAGE_RST}, PSM_RESP_OKAY);
        axi_rd(PSM_OFF_WINDOW_PAGE, {24'h0, PSM_WINDOW_PAGE_RST}, PSM_RESP_OKAY);
        axi_rd(PSM_OFF_CORE_CONTROL, {16'h0, PSM_CORE_CONTROL_RST}, PSM_RESP_OKAY);
        axi_rd(PSM_OFF_STATUS, 32'h0, PSM_RESP_OKAY);
        axi_rd(8'h10, 32'h0, PSM_RESP_SLVERR);
        axi_wr(PSM_OFF_TABLE_PAGE, 32'h12);
        axi_wr(PSM_OFF_WINDOW_PAGE, 32'hff);
        axi_wr(PSM_OFF_CORE_CONTROL, 32'h1 << PSM_WIN_EN_POS);
        axi_rd(PSM_OFF_WINDOW_PAGE, 32'hff, PSM_RESP_OKAY);
        axi_rd(PSM_OFF_CORE_CONTROL, 32'h4, PSM_RESP_OKAY);
        psm_pc <= 23'h2abcd3;
        acc(PSM_K_FETCH, 16'h0, 3, 24'h2abcd2, pat(24'h2abcd2));
        // Window is on and EA bit 15 is set, yet table kinds must take the table path.
        w = pat(24'h12b3c4);
        for (int i = 0; i < 6; i++) begin
            psm_byte <= (i % 3) != 0;
            acc(i < 3 ? PSM_K_TBL_LOW : PSM_K_TBL_HIGH, 16'hb3c4 | ((i % 3) == 2), 3, 24'h12b3c4,
                i == 0 ? w[15:0] : i == 1 ? w[7:0] : i == 2 ? w[15:8] : i == 5 ? 8'h0 : w[23:16]);
        end
        psm_byte <= 1'b0;
        axi_wr(PSM_OFF_TABLE_PAGE, 32'h92);
        w = pat(24'h92b3c4);
        acc(PSM_K_TBL_HIGH, 16'hb3c4, 3, 24'h92b3c4, {8'h0, w[23:16]});
        psm_write <= 1'b1;
        psm_wdata <= 16'hc0de;
        acc(PSM_K_TBL_LOW, 16'h0104, 3, 24'h920104, 24'h0);
        psm_wdata <= 16'h55a7;
        acc(PSM_K_TBL_HIGH, 16'h0104, 3, 24'h920104, 24'h0);
        psm_write <= 1'b0;
        acc(PSM_K_TBL_LOW, 16'h0104, 3, 24'h920104, 24'hc0de);
        acc(PSM_K_TBL_HIGH, 16'h0104, 3, 24'h920104, 24'h00a7);
        // Window page 0xff must still leave address bit 23 clear.
        w = pat(24'h7f9200);
        for (int c = 0; c < 6; c++) begin
            psm_class <= c[1:0];
            psm_in_repeat <= c > 3;
            psm_rep_edge <= c == 4;
            acc(PSM_K_DATA, 16'h9200, (c == 0 || c == 4) ? 5 : (c == 5 ? 3 : 4), 24'h7f9200, {8'h0, w[15:0]});
        end
        psm_in_repeat <= 1'b0;
        psm_rep_edge <= 1'b0;
        axi_rd(PSM_OFF_STATUS, 32'h6, PSM_RESP_OKAY);
        acc(PSM_K_DATA, 16'h1200, 0, 24'h0, 24'h0);
        axi_wr(PSM_OFF_CORE_CONTROL, 32'h0);
        acc(PSM_K_DATA, 16'h9200, 0, 24'h0, 24'h0);
        axi_rd(PSM_OFF_STATUS, 32'h6, PSM_RESP_OKAY);
        print_verdict();
    end

    // The tests need about two hundred cycles; twenty thousand means a hang.
    initial begin
        #400000;
        mismatches++;
        print_verdict();
    end
endmodule // psm_mapper_tb
